// [hdl/ramp_gen_pkg.sv]
// constants for the fmcw ramp generator
package ramp_gen_pkg;
  localparam int HOP_WORD_W = 16;
  localparam int HOP_SHIFT_W = 4;
  localparam int TIMER_W = 12;
  localparam int COUNT_W = 20;
  localparam int DIVIDER_W = 37;
  localparam int NUM_SLOPES = 4;
  localparam int DELAY_W = 12;
  localparam int FREQ_CNT_W = 16;
  localparam logic [1:0] MODE_CONT_SAW = 2'h0;
  localparam logic [1:0] MODE_ONE_SAW = 2'h1;
  localparam logic [1:0] MODE_CONT_TRI = 2'h2;
  localparam logic [1:0] MODE_ONE_BURST = 2'h3;
  localparam logic [1:0] TIMER_MODE_RAMP = 2'h3;
  localparam logic [3:0] DIAG_SEL_RAMP = 4'hF;
  localparam logic [14:0] DIAG_RAMP_DONE = 15'h00C0;
  localparam logic [14:0] DIAG_RAMP_DOWN = 15'h0100;
  localparam logic [5:0] READBACK_FREQ = 6'h1A;
  localparam logic [DIVIDER_W-1:0] DIVIDER_RESET = 37'h0;
  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_DELAY = 3'b001,
    ST_SLOPE = 3'b010,
    ST_DONE = 3'b011
  } ramp_state_t;
endpackage

// [hdl/hop_timer.sv]
// two-stage step timer: a then b compare-clock periods per tick
`timescale 1ns/1ps
module hop_timer
  import ramp_gen_pkg::*;
(
  input wire logic i_clk,
  input wire logic i_rst,
  input wire logic i_run,
  input wire logic [TIMER_W-1:0] i_div_a,
  input wire logic [TIMER_W-1:0] i_div_b,
  output logic o_tick
);
  logic [TIMER_W-1:0] cnt_a;
  logic [TIMER_W-1:0] cnt_b;
  logic wrap_a;
  logic wrap_b;

  // zero divider is treated as one
  assign wrap_a = (cnt_a + 12'h001 >= i_div_a);
  assign wrap_b = (cnt_b + 12'h001 >= i_div_b);

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      cnt_a <= '0;
      cnt_b <= '0;
      o_tick <= 1'b0;
    end else if (!i_run) begin
      cnt_a <= '0;
      cnt_b <= '0;
      o_tick <= 1'b0;
    end else begin
      o_tick <= 1'b0;
      if (wrap_a) begin
        cnt_a <= '0;
        if (wrap_b) begin
          cnt_b <= '0;
          o_tick <= 1'b1;
        end else begin
          cnt_b <= cnt_b + 12'h001;
        end
      end else begin
        cnt_a <= cnt_a + 12'h001;
      end
    end
  end
endmodule

// [hdl/fmcw_ramp_generator.sv]
// fmcw ramp sequencer, divider-word stepping, diagnostic out, frequency counter
// Summary of operation
// - hop equals signed word shifted by shift
// - shift field is four-bit power of two
// - step lasts div_a times div_b cycles
// - twenty-bit count sets hops per slope
// - four sections: optional delay then slope
// - writes steer to the selected slope
// - div_a shared; others stored per slope
// - delays only when delay enable set
// - mode 00 saw slopes 0,2; 10 triangle
// - mode 01 single saw; 11 burst/triangle
// - ramp complete marker on diagnostic pin
// - ramp down indication on diagnostic pin
// - external trigger replaces timer when enabled
// - readback 26 outputs frequency counter
`timescale 1ns/1ps
module fmcw_ramp_generator
  import ramp_gen_pkg::*;
(
  input wire logic i_clk,
  input wire logic i_rst,
  input wire logic i_ramp_enable,
  input wire logic [DIVIDER_W-1:0] i_start_divider,
  input wire logic [1:0] i_ramp_mode,
  input wire logic i_one_shot_full_triangle,
  input wire logic i_delay_enable,
  input wire logic [DELAY_W-1:0] i_delay_len,
  input wire logic [TIMER_W-1:0] i_hop_timer_div_a,
  input wire logic i_timer_wr,
  input wire logic [1:0] i_timer_slope_pick,
  input wire logic [TIMER_W-1:0] i_hop_timer_div_b,
  input wire logic [1:0] i_timer_mode,
  input wire logic i_hop_size_wr,
  input wire logic [1:0] i_hop_size_slope_pick,
  input wire logic [HOP_WORD_W-1:0] i_hop_size_word,
  input wire logic [HOP_SHIFT_W-1:0] i_hop_size_shift,
  input wire logic i_ext_step_enable,
  input wire logic i_hop_count_wr,
  input wire logic [1:0] i_hop_count_slope_pick,
  input wire logic [COUNT_W-1:0] i_hop_count,
  input wire logic [3:0] i_diag_select,
  input wire logic [14:0] i_diag_source,
  input wire logic [5:0] i_readback_ctrl,
  input wire logic i_readback_shift,
  input wire logic i_external_hop_trigger,
  output logic [DIVIDER_W-1:0] o_divider_word,
  output logic o_diagnostic_out_pin,
  output logic o_serial_readback_out,
  output logic o_ramp_busy,
  output logic [1:0] o_active_slope
);
  logic [TIMER_W-1:0] div_b_mem [NUM_SLOPES];
  logic [HOP_WORD_W-1:0] word_mem [NUM_SLOPES];
  logic [HOP_SHIFT_W-1:0] shift_mem [NUM_SLOPES];
  logic [COUNT_W-1:0] count_mem [NUM_SLOPES];
  logic trig_s1;
  logic trig_s2;
  logic trig_s3;
  logic ext_pulse;
  ramp_state_t state;
  ramp_state_t next_state;
  logic [1:0] slope;
  logic [1:0] next_slope;
  logic [COUNT_W-1:0] hops_left;
  logic [DELAY_W-1:0] delay_cnt;
  logic timer_tick;
  logic step;
  logic slope_end;
  logic last_slope;
  logic [DIVIDER_W-1:0] scaled_hop;
  logic ramp_done;
  logic [FREQ_CNT_W-1:0] freq_cnt;
  logic [FREQ_CNT_W-1:0] shadow;

  // per-slope storage, steered by the pick fields
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      for (int i = 0; i < NUM_SLOPES; i++) begin
        div_b_mem[i] <= 12'h001;
        word_mem[i] <= '0;
        shift_mem[i] <= '0;
        count_mem[i] <= '0;
      end
    end else begin
      if (i_timer_wr) div_b_mem[i_timer_slope_pick] <= i_hop_timer_div_b;
      if (i_hop_size_wr) begin
        word_mem[i_hop_size_slope_pick] <= i_hop_size_word;
        shift_mem[i_hop_size_slope_pick] <= i_hop_size_shift;
      end
      if (i_hop_count_wr) count_mem[i_hop_count_slope_pick] <= i_hop_count;
    end
  end

  // external trigger is asynchronous: two stages, then edge detect
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      trig_s1 <= 1'b0;
      trig_s2 <= 1'b0;
      trig_s3 <= 1'b0;
    end else begin
      trig_s1 <= i_external_hop_trigger;
      trig_s2 <= trig_s1;
      trig_s3 <= trig_s2;
    end
  end
  assign ext_pulse = trig_s2 & ~trig_s3;

  hop_timer u_hop_timer (
    .i_clk(i_clk),
    .i_rst(i_rst),
    .i_run((state == ST_SLOPE) && !i_ext_step_enable && (i_timer_mode == TIMER_MODE_RAMP)),
    .i_div_a(i_hop_timer_div_a),
    .i_div_b(div_b_mem[slope]),
    .o_tick(timer_tick)
  );

  assign step = (state == ST_SLOPE) && (i_ext_step_enable ? ext_pulse : timer_tick);
  assign slope_end = step && (hops_left <= 20'h00001);
  // sign-extend, then shift left by the power-of-two exponent
  assign scaled_hop = DIVIDER_W'({{(DIVIDER_W-HOP_WORD_W){word_mem[slope][HOP_WORD_W-1]}}, word_mem[slope]}
                      << shift_mem[slope]);

  always_comb begin
    last_slope = 1'b0;
    next_slope = slope + 2'h1;
    case (i_ramp_mode)
      MODE_CONT_SAW: next_slope = (slope == 2'h0) ? 2'h2 : 2'h0;
      MODE_CONT_TRI: next_slope = slope + 2'h1;
      MODE_ONE_SAW: last_slope = 1'b1;
      default: last_slope = !i_one_shot_full_triangle || (slope == 2'h1);
    endcase
  end

  always_comb begin
    next_state = state;
    case (state)
      ST_IDLE: if (i_ramp_enable) next_state = i_delay_enable ? ST_DELAY : ST_SLOPE;
      ST_DELAY: if (delay_cnt == '0) next_state = ST_SLOPE;
      ST_SLOPE: if (slope_end) next_state = last_slope ? ST_DONE : (i_delay_enable ? ST_DELAY : ST_SLOPE);
      ST_DONE: next_state = ST_DONE;
      default: next_state = ST_IDLE;
    endcase
    if (!i_ramp_enable) next_state = ST_IDLE;
  end

  // section sequencing: delay then slope, four sections
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      state <= ST_IDLE;
      slope <= 2'h0;
      hops_left <= '0;
      delay_cnt <= '0;
    end else begin
      state <= next_state;
      if (state == ST_IDLE) begin
        slope <= 2'h0;
        hops_left <= count_mem[0];
        delay_cnt <= i_delay_len;
      end else if (state == ST_DELAY) begin
        if (delay_cnt != '0) delay_cnt <= delay_cnt - 12'h001;
      end else if (state == ST_SLOPE && slope_end && !last_slope) begin
        slope <= next_slope;
        hops_left <= count_mem[next_slope];
        delay_cnt <= i_delay_len;
      end else if (step) begin
        hops_left <= hops_left - 20'h00001;
      end
    end
  end

  // divider word accumulates signed hops
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      o_divider_word <= DIVIDER_RESET;
    end else if (state == ST_IDLE) begin
      o_divider_word <= i_start_divider;
    end else if (step) begin
      o_divider_word <= o_divider_word + scaled_hop;
    end
  end

  assign ramp_done = (state == ST_SLOPE) && slope_end && last_slope;

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      o_diagnostic_out_pin <= 1'b0;
      o_ramp_busy <= 1'b0;
      o_active_slope <= 2'h0;
    end else begin
      o_ramp_busy <= (next_state == ST_DELAY) || (next_state == ST_SLOPE);
      o_active_slope <= slope;
      if (i_diag_select == DIAG_SEL_RAMP && i_diag_source == DIAG_RAMP_DONE)
        o_diagnostic_out_pin <= ramp_done;
      else if (i_diag_select == DIAG_SEL_RAMP && i_diag_source == DIAG_RAMP_DOWN)
        o_diagnostic_out_pin <= (state == ST_SLOPE) && slope[0];
      else
        o_diagnostic_out_pin <= 1'b0;
    end
  end

  // free-running wrapping counter; the host handles wrap on differences
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      freq_cnt <= '0;
      shadow <= '0;
      o_serial_readback_out <= 1'b0;
    end else begin
      freq_cnt <= freq_cnt + 16'h0001;
      if (i_readback_ctrl != READBACK_FREQ) begin
        shadow <= freq_cnt;
        o_serial_readback_out <= 1'b0;
      end else if (i_readback_shift) begin
        o_serial_readback_out <= shadow[FREQ_CNT_W-1];
        shadow <= {shadow[FREQ_CNT_W-2:0], 1'b0};
      end
    end
  end
endmodule

// [testbench/ramp_host.sv]
// host model: loads per-slope step time, hop size and hop count
`timescale 1ns/1ps
module ramp_host
  import ramp_gen_pkg::*;
(
  input wire logic i_clk,
  output logic o_wr = 1'b0,
  output logic [1:0] o_pick = 2'h0,
  output logic [TIMER_W-1:0] o_div_b = 12'h001,
  output logic [HOP_WORD_W-1:0] o_word = 16'h0000,
  output logic [HOP_SHIFT_W-1:0] o_shift = 4'h0,
  output logic [COUNT_W-1:0] o_count = 20'h00000,
  output logic [1:0] o_timer_mode = TIMER_MODE_RAMP
);
  // one strobe loads all three per-slope values; fields hold past the sampling edge
  task automatic put_slope(input logic [1:0] s, input logic [TIMER_W-1:0] b, input logic [HOP_WORD_W-1:0] w,
    input logic [HOP_SHIFT_W-1:0] sh, input logic [COUNT_W-1:0] n);
    @(negedge i_clk);
    o_pick = s;
    o_div_b = b;
    o_word = w;
    o_shift = sh;
    o_count = n;
    o_wr = 1'b1;
    @(negedge i_clk);
    o_wr = 1'b0;
  endtask
endmodule

// [testbench/fmcw_ramp_asserts.sv]
// port-level assertions for the fmcw ramp generator
`timescale 1ns/1ps
module fmcw_ramp_checker
  import ramp_gen_pkg::*;
(
  input wire logic i_clk,
  input wire logic i_rst,
  input wire logic i_ramp_enable,
  input wire logic [1:0] i_ramp_mode,
  input wire logic i_one_shot_full_triangle,
  input wire logic [3:0] i_diag_select,
  input wire logic [14:0] i_diag_source,
  input wire logic [DIVIDER_W-1:0] o_divider_word,
  input wire logic o_diagnostic_out_pin,
  input wire logic o_ramp_busy,
  input wire logic [1:0] o_active_slope
);
  default clocking @(posedge i_clk); endclocking
  default disable iff (i_rst);
  wire down_cfg = i_diag_select == DIAG_SEL_RAMP && i_diag_source == DIAG_RAMP_DOWN;
  wire done_cfg = i_diag_select == DIAG_SEL_RAMP && i_diag_source == DIAG_RAMP_DONE;
  a_start_goes_busy: assert property ($rose(i_ramp_enable) |-> ##[1:3] o_ramp_busy)
    else $error("ramp did not start");
  a_idle_not_busy: assert property (!i_ramp_enable [*3] |-> !o_ramp_busy)
    else $error("busy while disabled");
  // four cycles: the idle reload of the start word may land late
  a_idle_word_held: assert property (!i_ramp_enable [*4] |-> $stable(o_divider_word))
    else $error("idle word moved");
  a_saw_even_slopes: assert property (o_ramp_busy && i_ramp_mode == MODE_CONT_SAW |-> !o_active_slope[0])
    else $error("odd slope in sawtooth");
  a_single_saw_slope: assert property (o_ramp_busy && i_ramp_mode == MODE_ONE_SAW |-> o_active_slope == 2'h0)
    else $error("single saw left slope 0");
  a_burst_slopes: assert property (o_ramp_busy && i_ramp_mode == MODE_ONE_BURST |->
    o_active_slope <= {1'b0, i_one_shot_full_triangle}) else $error("burst slope out of range");
  a_down_marker: assert property ((down_cfg && o_ramp_busy && $stable(o_active_slope)) [*2] |->
    o_diagnostic_out_pin == o_active_slope[0]) else $error("ramp-down marker wrong");
  a_done_one_cycle: assert property (done_cfg && o_diagnostic_out_pin |=> !o_diagnostic_out_pin)
    else $error("done marker too long");
  c_ramp_start: cover property ($rose(o_ramp_busy));
  c_done_mark: cover property (done_cfg && o_diagnostic_out_pin);
  c_last_slope: cover property (o_active_slope == 2'h3);
endmodule
bind fmcw_ramp_generator fmcw_ramp_checker u_fmcw_ramp_checker (.*);

// [testbench/tb.sv]
// self-checking bench for the fmcw ramp generator
`timescale 1ns/1ps
`define CHK(n, e, g) if ((g) !== (e)) miss(n, e, g); else tests_run++;
module tb;
  import ramp_gen_pkg::*;
  localparam logic [DIVIDER_W-1:0] ST = 37'h0002000000;
  logic i_clk = 1'b0, i_rst = 1'b1, i_ramp_enable = 1'b0, i_one_shot_full_triangle = 1'b0, i_delay_enable = 1'b0;
  logic i_ext_step_enable = 1'b0, i_external_hop_trigger = 1'b0, i_readback_shift = 1'b0;
  logic i_timer_wr, o_diagnostic_out_pin, o_serial_readback_out, o_ramp_busy;
  logic [1:0] i_ramp_mode = 2'h1, i_timer_mode, i_timer_slope_pick, o_active_slope;
  logic [3:0] i_diag_select = 4'hF, i_hop_size_shift;
  logic [5:0] i_readback_ctrl = 6'h00;
  logic [11:0] i_delay_len = 12'h014, i_hop_timer_div_a = 12'h002, i_hop_timer_div_b;
  logic [14:0] i_diag_source = 15'h00C0;
  logic [15:0] i_hop_size_word;
  logic [19:0] i_hop_count;
  logic [15:0] rb1, rb2;
  logic [DIVIDER_W-1:0] i_start_divider = ST, o_divider_word;
  wire i_hop_size_wr = i_timer_wr;
  wire i_hop_count_wr = i_timer_wr;
  wire [1:0] i_hop_size_slope_pick = i_timer_slope_pick;
  wire [1:0] i_hop_count_slope_pick = i_timer_slope_pick;
  int n_mismatch = 0, tests_run = 0, cyc = 0;
  // row: mode[12:11], full triangle[10], awaited slope[9:8] (0 = done pulse), rise over start[7:0]
  logic [12:0] rows [5] = '{13'h0818, 13'h1818, 13'h1C0C, 13'h120C, 13'h0218};
  ramp_host u_host (.i_clk, .o_wr(i_timer_wr), .o_pick(i_timer_slope_pick), .o_div_b(i_hop_timer_div_b),
    .o_word(i_hop_size_word), .o_shift(i_hop_size_shift), .o_count(i_hop_count), .o_timer_mode(i_timer_mode));
  fmcw_ramp_generator u_fmcw_ramp_generator (.*);
  always #4 i_clk = ~i_clk;
  always @(posedge i_clk) begin
    cyc++;
    if (cyc == 60000) begin
      n_mismatch++;
      report_and_stop();
    end
  end
  task automatic miss(input string n, input logic [DIVIDER_W-1:0] e, input logic [DIVIDER_W-1:0] g);
    tests_run++;
    n_mismatch++;
    $display("unexpected %s exp %h got %h", n, e, g);
  endtask
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", tests_run, n_mismatch);
    if (n_mismatch == 0 && tests_run > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  task automatic ticks(input int n);
    repeat (n) @(negedge i_clk);
  endtask
  // snapshot taken while control is off 26, then sixteen shifts, msb first
  task automatic read_count(output logic [15:0] v);
    i_readback_ctrl = 6'h00;
    ticks(1);
    i_readback_ctrl = READBACK_FREQ;
    i_readback_shift = 1'b1;
    repeat (16) begin
      ticks(1);
      v = {v[14:0], o_serial_readback_out};
    end
    i_readback_shift = 1'b0;
  endtask
  // early check lands before the first step could finish
  task automatic run(input logic [1:0] stop, input logic [7:0] rise, input int early);
    i_ramp_enable = 1'b1;
    ticks(early);
    `CHK("early word", ST, o_divider_word)
    for (int k = 0; k < 300 && !(stop == 2'h0 ? o_diagnostic_out_pin === 1'b1 : o_active_slope === stop); k++) ticks(1);
    ticks(2);
    `CHK("ramp word", ST + rise, o_divider_word)
    i_ramp_enable = 1'b0;
    ticks(5);
  endtask
  initial begin
    ticks(5);
    i_rst = 1'b0;
    u_host.put_slope(2'h3, 12'h002, 16'hFFFF, 4'h3, 20'h00002);
    u_host.put_slope(2'h2, 12'h003, 16'h0001, 4'h0, 20'h00002);
    u_host.put_slope(2'h1, 12'h001, 16'hFFFF, 4'h2, 20'h00003);
    u_host.put_slope(2'h0, 12'h002, 16'h0003, 4'h1, 20'h00004);
    for (int i = 0; i < 5; i++) begin
      i_ramp_mode = rows[i][12:11];
      i_one_shot_full_triangle = rows[i][10];
      i_diag_source = rows[i][9:8] == 2'h0 ? DIAG_RAMP_DONE : DIAG_RAMP_DOWN;
      ticks(1);
      run(rows[i][9:8], rows[i][7:0], 3);
      $display("row %0d done", i);
    end
    i_ramp_mode = MODE_ONE_SAW;
    i_diag_source = DIAG_RAMP_DONE;
    i_delay_enable = 1'b1;
    run(2'h0, 8'h18, 16);
    $display("delay test done");
    i_delay_enable = 1'b0;
    u_host.o_timer_mode = 2'h0;
    i_readback_ctrl = READBACK_FREQ;
    i_ramp_enable = 1'b1;
    ticks(30);
    `CHK("idle timer word", ST, o_divider_word)
    i_ext_step_enable = 1'b1;
    for (int k = 1; k <= 4; k++) begin
      i_external_hop_trigger = 1'b1;
      ticks(3);
      i_external_hop_trigger = 1'b0;
      ticks(8);
      `CHK("trigger word", ST + 37'(6 * k), o_divider_word)
    end
    $display("trigger test done");
    read_count(rb1);
    i_ramp_enable = 1'b0;
    i_hop_timer_div_a = 12'h710;
    u_host.o_timer_mode = 2'h2;
    u_host.put_slope(2'h0, 12'h00A, 16'h0003, 4'h1, 20'h00004);
    ticks(53500);
    read_count(rb2);
    // snapshots sit 17 + 2 + 53500 cycles apart; the cast keeps any wrap
    `CHK("count delta", 16'hD10F, 16'(rb2 - rb1))
    i_readback_ctrl = 6'h00;
    ticks(1);
    `CHK("readback idle", 1'b0, o_serial_readback_out)
    $display("readback test done");
    i_ramp_enable = 1'b0;
    i_ext_step_enable = 1'b0;
    u_host.o_timer_mode = TIMER_MODE_RAMP;
    i_ramp_mode = MODE_CONT_TRI;
    ticks(5);
    i_ramp_enable = 1'b1;
    ticks(10);
    i_rst = 1'b1;
    ticks(2);
    `CHK("reset word", 37'h0, o_divider_word)
    `CHK("reset busy", 1'b0, o_ramp_busy)
    `CHK("reset slope", 2'h0, o_active_slope)
    i_rst = 1'b0;
    ticks(3);
    `CHK("restart busy", 1'b1, o_ramp_busy)
    `CHK("restart word", ST, o_divider_word)
    $display("reset test done");
    report_and_stop();
  end
endmodule
